// file: rtl/watchdog_pkg.sv
package watchdog_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 20000000;
  localparam int unsigned OSC_FREQ_HZ = 10000;
  localparam int unsigned OSC_TICK_CYCLES = CLK_FREQ_HZ / OSC_FREQ_HZ;

  // ----------------------------------------------------------------
  // apb register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h04;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_COUNT = 8'h14;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_OSC_RUN_BIT = 0;
  localparam int unsigned STAT_WDT_BIT = 0;
  localparam int unsigned STAT_STOP_BIT = 1;
  localparam int unsigned STAT_EXC_BIT = 2;
  localparam int unsigned STAT_WIDTH = 3;
  localparam int unsigned COUNT_ENABLED_BIT = 16;
  localparam logic [7:0] RELOAD_HIGH_RESET = 8'h04;
  localparam logic [7:0] RELOAD_LOW_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0400;
  localparam logic CTRL_OSC_RUN_RESET = 1'b1;
  localparam logic [2:0] STAT_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UNLOCK_IDLE,
    UNLOCK_GOT_FIRST,
    UNLOCK_OPEN_HIGH,
    UNLOCK_OPEN_LOW
  } unlock_state_t;

endpackage : watchdog_pkg

// file: rtl/watchdog_osc_tick.sv
`timescale 1ns/100ps
module watchdog_osc_tick #(
  parameter int unsigned TICK_CYCLES = watchdog_pkg::OSC_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic osc_run_enable_i,
  output logic tick_o
);

  // ----------------------------------------------------------------
  // divider standing in for the private rc oscillator
  // ----------------------------------------------------------------
  localparam logic [15:0] LAST = 16'(TICK_CYCLES - 1);

  logic [15:0] div_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i || !osc_run_enable_i) begin
      div_reg <= 16'h0000;
    end else if (div_reg == LAST) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= osc_run_enable_i && (div_reg == LAST);
    end
  end

endmodule : watchdog_osc_tick

// file: rtl/watchdog_downcounter.sv
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module watchdog_downcounter #(
  parameter int unsigned TICK_CYCLES = watchdog_pkg::OSC_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic watchdog_refresh_instruction_i,
  input wire logic always_on_option_i,
  input wire logic timeout_response_select_i,
  input wire logic debug_mode_i,
  input wire logic stop_mode_i,
  output logic exception_req_o,
  output logic reset_req_o,
  output logic stop_recovery_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic osc_run_enable_reg;
  logic [7:0] reload_high_byte_reg;
  logic [7:0] reload_low_byte_reg;
  watchdog_pkg::unlock_state_t unlock_reg;
  watchdog_pkg::unlock_state_t unlock_next;
  logic enabled_reg;
  logic [15:0] count_reg;
  logic [2:0] status_reg;
  logic [2:0] mask_reg;
  logic [2:0] status_set;
  logic osc_tick;
  logic [15:0] reload_value;
  logic refresh_now;
  logic enable_now;
  logic timeout_now;
  logic setup_phase;
  logic wr_en;
  logic wr_high;
  logic wr_low;
  logic [31:0] read_mux;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == watchdog_pkg::ADDR_CTRL) ||
                (addr == watchdog_pkg::ADDR_RELOAD_HIGH) ||
                (addr == watchdog_pkg::ADDR_RELOAD_LOW) ||
                (addr == watchdog_pkg::ADDR_STATUS) ||
                (addr == watchdog_pkg::ADDR_MASK) ||
                (addr == watchdog_pkg::ADDR_COUNT);
  endfunction : is_mapped

  // ----------------------------------------------------------------
  // oscillator tick
  // ----------------------------------------------------------------
  watchdog_osc_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_osc_tick (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .osc_run_enable_i(osc_run_enable_reg),
    .tick_o(osc_tick)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup_phase = psel_i && !penable_i;
  assign wr_en = psel_i && penable_i && pready_o && pwrite_i
                 && is_mapped(paddr_i);
  assign wr_high = wr_en && (paddr_i == watchdog_pkg::ADDR_RELOAD_HIGH);
  assign wr_low = wr_en && (paddr_i == watchdog_pkg::ADDR_RELOAD_LOW);

  always_comb begin
    read_mux = 32'h0000_0000;
    case (paddr_i)
      watchdog_pkg::ADDR_CTRL: begin
        read_mux[watchdog_pkg::CTRL_OSC_RUN_BIT] = osc_run_enable_reg;
      end
      watchdog_pkg::ADDR_RELOAD_HIGH: begin
        read_mux[7:0] = count_reg[15:8];
      end
      watchdog_pkg::ADDR_RELOAD_LOW: begin
        read_mux[7:0] = count_reg[7:0];
      end
      watchdog_pkg::ADDR_STATUS: begin
        read_mux[2:0] = status_reg;
      end
      watchdog_pkg::ADDR_MASK: begin
        read_mux[2:0] = mask_reg;
      end
      watchdog_pkg::ADDR_COUNT: begin
        read_mux[15:0] = count_reg;
        read_mux[watchdog_pkg::COUNT_ENABLED_BIT] = enabled_reg;
      end
      default: begin
        read_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= setup_phase;
      pslverr_o <= setup_phase && !is_mapped(paddr_i);
      if (setup_phase && !pwrite_i) begin
        prdata_o <= read_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      osc_run_enable_reg <= watchdog_pkg::CTRL_OSC_RUN_RESET;
    end else if (wr_en && (paddr_i == watchdog_pkg::ADDR_CTRL)) begin
      osc_run_enable_reg <= pwdata_i[watchdog_pkg::CTRL_OSC_RUN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // reload unlock sequence
  // ----------------------------------------------------------------
  always_comb begin
    unlock_next = unlock_reg;
    case (unlock_reg)
      watchdog_pkg::UNLOCK_IDLE: begin
        if (wr_high && pwdata_i[7:0] == watchdog_pkg::UNLOCK_FIRST) begin
          unlock_next = watchdog_pkg::UNLOCK_GOT_FIRST;
        end
      end
      watchdog_pkg::UNLOCK_GOT_FIRST: begin
        if (wr_high) begin
          if (pwdata_i[7:0] == watchdog_pkg::UNLOCK_SECOND) begin
            unlock_next = watchdog_pkg::UNLOCK_OPEN_HIGH;
          end else begin
            unlock_next = watchdog_pkg::UNLOCK_IDLE;
          end
        end else if (wr_low) begin
          unlock_next = watchdog_pkg::UNLOCK_IDLE;
        end
      end
      watchdog_pkg::UNLOCK_OPEN_HIGH: begin
        if (wr_high) begin
          unlock_next = watchdog_pkg::UNLOCK_OPEN_LOW;
        end else if (wr_low) begin
          unlock_next = watchdog_pkg::UNLOCK_IDLE;
        end
      end
      watchdog_pkg::UNLOCK_OPEN_LOW: begin
        if (wr_high || wr_low) begin
          unlock_next = watchdog_pkg::UNLOCK_IDLE;
        end
      end
      default: begin
        unlock_next = watchdog_pkg::UNLOCK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      unlock_reg <= watchdog_pkg::UNLOCK_IDLE;
    end else begin
      unlock_reg <= unlock_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reload_high_byte_reg <= watchdog_pkg::RELOAD_HIGH_RESET;
      reload_low_byte_reg <= watchdog_pkg::RELOAD_LOW_RESET;
    end else begin
      if (wr_high && unlock_reg == watchdog_pkg::UNLOCK_OPEN_HIGH) begin
        reload_high_byte_reg <= pwdata_i[7:0];
      end
      if (wr_low && unlock_reg == watchdog_pkg::UNLOCK_OPEN_LOW) begin
        reload_low_byte_reg <= pwdata_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // down-counter
  // ----------------------------------------------------------------
  assign reload_value = {reload_high_byte_reg, reload_low_byte_reg};
  assign refresh_now = watchdog_refresh_instruction_i || debug_mode_i;
  assign enable_now = !enabled_reg &&
    (watchdog_refresh_instruction_i || always_on_option_i);
  assign timeout_now = enabled_reg && osc_tick && !refresh_now &&
    (count_reg <= 16'h0001);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      enabled_reg <= 1'b0;
    end else if (enable_now) begin
      enabled_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_reg <= watchdog_pkg::COUNT_RESET;
    end else if (enable_now) begin
      count_reg <= reload_value;
    end else if (enabled_reg && refresh_now) begin
      count_reg <= reload_value;
    end else if (timeout_now) begin
      count_reg <= reload_value;
    end else if (enabled_reg && osc_tick) begin
      count_reg <= count_reg - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // time-out response
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      exception_req_o <= 1'b0;
      reset_req_o <= 1'b0;
      stop_recovery_o <= 1'b0;
    end else begin
      exception_req_o <= timeout_now && !timeout_response_select_i;
      reset_req_o <= timeout_now && timeout_response_select_i
                     && !stop_mode_i;
      stop_recovery_o <= timeout_now && stop_mode_i;
    end
  end

  // ----------------------------------------------------------------
  // status, mask and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    status_set = 3'h0;
    status_set[watchdog_pkg::STAT_WDT_BIT] = timeout_now &&
      (timeout_response_select_i || stop_mode_i);
    status_set[watchdog_pkg::STAT_STOP_BIT] = timeout_now
      && stop_mode_i;
    status_set[watchdog_pkg::STAT_EXC_BIT] = timeout_now &&
      !timeout_response_select_i;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      status_reg <= watchdog_pkg::STAT_RESET;
    end else if (wr_en && paddr_i == watchdog_pkg::ADDR_STATUS) begin
      status_reg <= (status_reg & ~pwdata_i[2:0]) | status_set;
    end else begin
      status_reg <= status_reg | status_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mask_reg <= watchdog_pkg::MASK_RESET;
    end else if (wr_en && paddr_i == watchdog_pkg::ADDR_MASK) begin
      mask_reg <= pwdata_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_reg & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  a_load_on_enable: assert property (
    enable_now |=> count_reg == $past(reload_value))
    else $error("first enable did not load reload value");

  a_refresh_reload: assert property (
    enabled_reg && watchdog_refresh_instruction_i
    |=> count_reg == $past(reload_value))
    else $error("refresh did not reload counter");

  a_debug_no_timeout: assert property (
    debug_mode_i |=> !exception_req_o && !reset_req_o && !stop_recovery_o)
    else $error("time-out seen during debug mode");

  a_osc_stop_hold: assert property (
    !osc_run_enable_reg && !osc_tick && !refresh_now && !enable_now
    |=> $stable(count_reg))
    else $error("counter moved with oscillator stopped");

  a_decrement_tick: assert property (
    enabled_reg && osc_tick && !refresh_now && !timeout_now
    |=> count_reg == $past(count_reg) - 16'h0001)
    else $error("counter did not decrement by one on tick");

  a_exc_timeout: assert property (
    timeout_now && !timeout_response_select_i
    |=> exception_req_o && count_reg == $past(reload_value)
    ##1 !exception_req_o)
    else $error("exception time-out response wrong");

  a_reset_timeout: assert property (
    timeout_now && timeout_response_select_i && !stop_mode_i
    |=> reset_req_o && status_reg[watchdog_pkg::STAT_WDT_BIT])
    else $error("reset time-out response wrong");

  a_stop_timeout: assert property (
    timeout_now && stop_mode_i |=> stop_recovery_o
    && status_reg[watchdog_pkg::STAT_WDT_BIT]
    && status_reg[watchdog_pkg::STAT_STOP_BIT])
    else $error("stop-mode time-out did not set both flags");

  a_stays_on: assert property (
    enabled_reg |=> enabled_reg)
    else $error("watchdog turned off while running");

  a_always_on: assert property (
    always_on_option_i |=> enabled_reg)
    else $error("always-on option did not enable");

  a_read_live: assert property (
    setup_phase && !pwrite_i && paddr_i == watchdog_pkg::ADDR_RELOAD_HIGH
    |=> prdata_o[7:0] == $past(count_reg[15:8]))
    else $error("reload high read not live count");

  a_unlock_guard: assert property (
    wr_high && unlock_reg != watchdog_pkg::UNLOCK_OPEN_HIGH
    |=> $stable(reload_high_byte_reg))
    else $error("reload high changed without unlock");

  c_exc_timeout: cover property (timeout_now && !timeout_response_select_i);
  c_reset_timeout: cover property (timeout_now && timeout_response_select_i);
  c_stop_timeout: cover property (timeout_now && stop_mode_i);
  c_unlock_done: cover property (
    wr_low && unlock_reg == watchdog_pkg::UNLOCK_OPEN_LOW);

endmodule : watchdog_downcounter

// file: dv/watchdog_core_partner.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// interrupt and reset controller side: counts response pulses
// ------------------------------------------------------------
module watchdog_core_partner (
  input wire logic clk_i,
  input wire logic exception_req_i,
  input wire logic reset_req_i,
  input wire logic stop_recovery_i,
  output int exc_count_o,
  output int rst_count_o,
  output int rec_count_o
);
  always_ff @(posedge clk_i) begin
    if (exception_req_i) begin
      exc_count_o <= exc_count_o + 1;
    end
    if (reset_req_i) begin
      rst_count_o <= rst_count_o + 1;
    end
    if (stop_recovery_i) begin
      rec_count_o <= rec_count_o + 1;
    end
  end
endmodule : watchdog_core_partner

// file: dv/watchdog_downcounter_tb.sv
`timescale 1ns/100ps
module watchdog_downcounter_tb;
  localparam int TICK = 4;
  localparam logic [7:0] A_CT = watchdog_pkg::ADDR_CTRL;
  localparam logic [7:0] A_RH = watchdog_pkg::ADDR_RELOAD_HIGH;
  localparam logic [7:0] A_RL = watchdog_pkg::ADDR_RELOAD_LOW;
  localparam logic [7:0] A_ST = watchdog_pkg::ADDR_STATUS;
  localparam logic [7:0] A_MK = watchdog_pkg::ADDR_MASK;
  localparam logic [7:0] A_CN = watchdog_pkg::ADDR_COUNT;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, err, exc, rst, rec, irq;
  logic refresh = 1'b0, always_on = 1'b0, resp_sel = 1'b0;
  logic debug = 1'b0, stop = 1'b0;
  logic [31:0] lfsr = 32'h85DF;
  logic [15:0] reload_m;
  logic [2:0] resp_exp;
  int exc_n, rst_n, rec_n, n, e0, mismatches = 0, tests_run = 0;

  always #25 clk_i = ~clk_i;

  watchdog_downcounter #(.TICK_CYCLES(TICK)) DUT (.clk_i(clk_i),
    .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .watchdog_refresh_instruction_i(refresh),
    .always_on_option_i(always_on),
    .timeout_response_select_i(resp_sel), .debug_mode_i(debug),
    .stop_mode_i(stop), .exception_req_o(exc), .reset_req_o(rst),
    .stop_recovery_o(rec), .irq_o(irq));

  watchdog_core_partner partner (.clk_i(clk_i), .exception_req_i(exc),
    .reset_req_i(rst), .stop_recovery_i(rec), .exc_count_o(exc_n),
    .rst_count_o(rst_n), .rec_count_o(rec_n));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task report_and_stop;
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      report_and_stop;
    end
    @(posedge clk_i);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd_chk(input string what, input logic [7:0] a,
              input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rdata, exp);
  endtask : rd_chk

  task unlock(input logic [15:0] v);
    wr(A_RH, {24'h0, watchdog_pkg::UNLOCK_FIRST});
    wr(A_RH, {24'h0, watchdog_pkg::UNLOCK_SECOND});
    wr(A_RH, {24'h0, v[15:8]});
    wr(A_RL, {24'h0, v[7:0]});
    reload_m = v;
  endtask : unlock

  task kick;
    refresh <= 1'b1;
    @(posedge clk_i);
    refresh <= 1'b0;
    @(posedge clk_i);
  endtask : kick

  function automatic int cnt(input int which);
    return (which == 0) ? exc_n : (which == 1) ? rst_n : rec_n;
  endfunction : cnt

  task wait_evt(input int which, input int limit);
    int old;
    old = cnt(which);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (cnt(which) == old && n < limit);
    if (cnt(which) == old) begin
      mismatches++;
      report_and_stop;
    end
  endtask : wait_evt

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr_next

  // ------------------------------------------------------------
  // model: which response pulses the options call for
  // ------------------------------------------------------------
  function automatic logic [2:0] resp_model(input logic sel,
                                            input logic stp);
    return {stp, sel && !stp, !sel};
  endfunction : resp_model

  always @(posedge clk_i) begin
    if (!reset_i && (exc || rst || rec)) begin
      resp_exp = resp_model(resp_sel, stop);
      check("resp", {29'h0, rec, rst, exc}, {29'h0, resp_exp});
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("ctrl", A_CT, 32'h1);
    rd_chk("count", A_CN, 32'h400);
    rd_chk("status", A_ST, 32'h0);
    rd_chk("mask", A_MK, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    wr(A_CT, 32'h0);
    kick;
    rd_chk("first load", A_CN, 32'h10400);
    wr(A_RH, 32'h12);
    kick;
    rd_chk("locked", A_CN, 32'h10400);
    lfsr = lfsr_next(lfsr);
    unlock(lfsr[15:0]);
    kick;
    rd_chk("reload", A_CN, {15'h0, 1'b1, reload_m});
    rd_chk("high", A_RH, {24'h0, reload_m[15:8]});
    rd_chk("low", A_RL, {24'h0, reload_m[7:0]});
    repeat (40) @(posedge clk_i);
    rd_chk("osc off", A_CN, {15'h0, 1'b1, reload_m});
    unlock(16'h0003);
    wr(A_MK, 32'h4);
    wr(A_CT, 32'h1);
    kick;
    wait_evt(0, 6 * TICK);
    check("first", 32'(n >= 2 * TICK), 32'h1);
    wait_evt(0, 6 * TICK);
    check("period", n, 3 * TICK);
    wr(A_CT, 32'h0);
    rd_chk("exc stat", A_ST, 32'h4);
    check("irq on", {31'h0, irq}, 32'h1);
    wr(A_ST, 32'h7);
    rd_chk("cleared", A_ST, 32'h0);
    check("irq off", {31'h0, irq}, 32'h0);
    e0 = exc_n;
    debug <= 1'b1;
    wr(A_CT, 32'h1);
    repeat (40) @(posedge clk_i);
    check("debug", exc_n, e0);
    debug <= 1'b0;
    stop <= 1'b1;
    wait_evt(2, 6 * TICK);
    check("stop exc", exc_n, e0 + 1);
    wr(A_CT, 32'h0);
    rd_chk("stop stat", A_ST, 32'h7);
    stop <= 1'b0;
    wr(A_ST, 32'h7);
    resp_sel <= 1'b1;
    wr(A_MK, 32'h1);
    wr(A_CT, 32'h1);
    wait_evt(1, 6 * TICK);
    wr(A_CT, 32'h0);
    rd_chk("rst stat", A_ST, 32'h1);
    check("irq rst", {31'h0, irq}, 32'h1);
    reset_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("after rst", A_CN, 32'h400);
    e0 = rst_n;
    stop <= 1'b1;
    always_on <= 1'b1;
    wait_evt(2, 1026 * TICK);
    check("always on", 32'(n >= 1023 * TICK), 32'h1);
    check("no rst", rst_n, e0);
    rd_chk("stop rst", A_ST, 32'h3);
    report_and_stop;
  end
endmodule : watchdog_downcounter_tb
